// [ohp_pkg.sv]
// Shared constants and types for the display host port.
package ohp_pkg;
    typedef enum logic [1:0] {
        OHP_SPI3 = 2'h1,
        OHP_SPI4 = 2'h2,
        OHP_P68  = 2'h3,
        OHP_P80  = 2'h0
    } ohp_mode_t;
    localparam int          OHP_BUS_W        = 8;
    localparam int          OHP_SERIAL_DATA_IN_BIT     = 1;
    localparam int          OHP_SCLK_BIT     = 0;
    localparam logic [7:0]  OHP_CONTRAST_RST = 8'h7f;
    localparam logic [7:0]  OHP_COL_RST      = 8'h00;
    localparam logic [6:0]  OHP_START_RST    = 7'h00;
    localparam logic [7:0]  OHP_CMD_DISP_OFF = 8'hae;
    localparam logic [7:0]  OHP_CMD_DISP_ON  = 8'haf;
    localparam logic [7:0]  OHP_CMD_CONTRAST = 8'hc1;
    localparam logic [7:0]  OHP_CMD_START    = 8'ha1;
    localparam logic [7:0]  OHP_COL_MAX      = 8'h77;
    localparam int          OHP_FRAME_NS     = 100000;
    localparam int          OHP_CLK_NS       = 100;
    localparam int          OHP_FRAME_CYC    = OHP_FRAME_NS / OHP_CLK_NS;
    localparam int          OHP_HOST_DIV     = 4;
endpackage : ohp_pkg

// [ohp_if.sv]
// Pin-level interface between the host controller and the display port.
`timescale 1ns/100ps
interface ohp_if;
    logic       protocol_select_low;
    logic       protocol_select_high;
    logic       init_input_n;
    logic       cs_n;
    logic       dc;
    logic       e_rd_n;
    logic       rw_wr_n;
    logic [7:0] host_bus_h_out;
    logic       host_bus_h_oe;
    logic [7:0] host_bus_d_out;
    logic       host_bus_d_oe;
    logic [7:0] host_bus;
    logic       frame_status_out;
    assign host_bus = host_bus_h_oe ? host_bus_h_out : (host_bus_d_oe ? host_bus_d_out : 8'h00);
    modport dev (input protocol_select_low, protocol_select_high, init_input_n, cs_n, dc, e_rd_n,
                 rw_wr_n, host_bus, output host_bus_d_out, host_bus_d_oe, frame_status_out);
    modport host (output protocol_select_low, protocol_select_high, init_input_n, cs_n, dc, e_rd_n,
                  rw_wr_n, host_bus_h_out, host_bus_h_oe, input host_bus, frame_status_out);
endinterface : ohp_if

// [ohp_device.sv]
// Display side of the host port: protocol decode, byte capture, command state, frame status.
`timescale 1ns/100ps
// How it works
// - Two straps pick one of four protocols.
// - Low init input restores all defaults; the frame status flop and its counter are not reset.
// - Transfers accepted only with select low.
// - Selector high is data, low command.
// - 68 mode: strobe high starts access.
// - 80 mode: read strobe low reads.
// - 68 mode: direction high read, low write.
// - 80 mode: write strobe low writes.
// - Serial modes: host grounds both strobes.
// - Parallel modes use eight-bit two-way bus.
// - Serial: bit one data, bit zero clock.
// - Serial: host grounds unused bus lines.
// - Frame status output shows refresh activity.
// - Init: display off, contrast default.
// - Init: column and start line zero.
module ohp_device
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // Host pins
    ohp_if.dev               pins,
    // Received bytes to display logic
    output logic [7:0]       rx_data,
    output logic             rx_is_data,
    output logic             rx_valid,
    input  wire logic        rx_ready,
    // Read-back source for display memory
    input  wire logic [7:0]  rd_data,
    // Command state
    output logic             display_on,
    output logic [7:0]       contrast,
    output logic [7:0]       column_addr,
    output logic [6:0]       start_line
);
    import ohp_pkg::*;

    // Every pin is off-domain and passes two flops before use.
    logic [12:0] sync1;
    logic [12:0] sync2;
    logic [12:0] prev;
    wire  [12:0] raw = {pins.protocol_select_high, pins.protocol_select_low, pins.init_input_n,
                        pins.cs_n, pins.dc, pins.e_rd_n, pins.rw_wr_n, pins.host_bus[5:0]};
    // Serial bit 7..6 are grounded by the host and not watched; bits 7..6 kept via a second path.
    logic [1:0]  hi1;
    logic [1:0]  hi2;

    always_ff @(posedge mclk or posedge sys_rst)
        if (sys_rst)
        begin
            sync1 <= 13'h0000;
            sync2 <= 13'h0000;
            prev  <= 13'h0000;
            hi1   <= 2'h0;
            hi2   <= 2'h0;
        end
        else
        begin
            sync1 <= raw;
            sync2 <= sync1;
            prev  <= sync2;
            hi1   <= pins.host_bus[7:6];
            hi2   <= hi1;
        end

    ohp_mode_t mode;
    assign mode = ohp_mode_t'(sync2[12:11]);
    wire init_n  = sync2[10];
    wire cs_n    = sync2[9];
    wire dc      = sync2[8];
    wire erd     = sync2[7];
    wire rww     = sync2[6];
    wire [7:0] bus = {hi2, sync2[5:0]};
    wire selected = !cs_n && init_n;
    wire serial   = (mode == OHP_SPI3) || (mode == OHP_SPI4);
    wire m68      = (mode == OHP_P68);
    wire m80      = (mode == OHP_P80);
    wire e_rise   = erd && !prev[7];
    wire e_fall   = !erd && prev[7];
    wire rd_fall  = !erd && prev[7];
    wire wr_rise  = rww && !prev[6];
    wire sclk_rise = bus[OHP_SCLK_BIT] && !prev[OHP_SCLK_BIT];
    // 68 mode latches writes on falling E so data is settled across the high phase.
    wire wr68     = m68 && selected && e_fall && !rww;
    wire rd68     = m68 && selected && erd && rww;
    wire wr80     = m80 && selected && wr_rise;
    wire rd80     = m80 && selected && !erd;
    wire par_wr   = wr68 || wr80;

    // Serial shifter; 3-wire sends the D/C bit first, 4-wire uses the pin.
    logic [8:0] shreg;
    logic [3:0] bitcnt;
    wire [3:0]  nbits   = (mode == OHP_SPI3) ? 4'h9 : 4'h8;
    wire        sbit    = serial && selected && sclk_rise;
    wire        sdone   = sbit && (bitcnt == nbits - 4'h1);
    wire [8:0]  next_sh = {shreg[7:0], bus[OHP_SERIAL_DATA_IN_BIT]};
    wire        s_dc    = (mode == OHP_SPI3) ? next_sh[8] : dc;

    always_ff @(posedge mclk or posedge sys_rst)
        if (sys_rst)
        begin
            shreg  <= 9'h000;
            bitcnt <= 4'h0;
        end
        else if (!selected || !serial)
        begin
            bitcnt <= 4'h0;
        end
        else if (sbit)
        begin
            shreg  <= next_sh;
            bitcnt <= sdone ? 4'h0 : bitcnt + 4'h1;
        end

    // Two-entry buffer between capture and the display logic.
    wire        in_valid = sdone || par_wr;
    wire [8:0]  in_word  = sdone ? {s_dc, next_sh[7:0]} : {dc, bus};
    logic [8:0] buf_mem [2];
    logic       wp;
    logic       rp;
    logic [1:0] cnt;
    wire        in_ready = cnt != 2'h2;
    wire        push     = in_valid && in_ready;
    wire        pop      = rx_valid && rx_ready;
    assign rx_valid   = cnt != 2'h0;
    assign rx_data    = buf_mem[rp][7:0];
    assign rx_is_data = buf_mem[rp][8];

    always_ff @(posedge mclk or posedge sys_rst)
        if (sys_rst)
        begin
            wp  <= 1'b0;
            rp  <= 1'b0;
            cnt <= 2'h0;
            buf_mem[0] <= 9'h000;
            buf_mem[1] <= 9'h000;
        end
        else if (!init_n)
        begin
            wp  <= 1'b0;
            rp  <= 1'b0;
            cnt <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                buf_mem[wp] <= in_word;
                wp <= !wp;
            end
            if (pop)
                rp <= !rp;
            cnt <= cnt + {1'b0, push} - {1'b0, pop};
        end

    // Command decode on accepted command bytes; one-byte argument for contrast and start line.
    logic [1:0] arg_for;
    wire cmd_take = push && !in_word[8];
    wire dat_take = push && in_word[8];

    always_ff @(posedge mclk or posedge sys_rst)
        if (sys_rst)
        begin
            display_on  <= 1'b0;
            contrast    <= OHP_CONTRAST_RST;
            column_addr <= OHP_COL_RST;
            start_line  <= OHP_START_RST;
            arg_for     <= 2'h0;
        end
        else if (!init_n)
        begin
            display_on  <= 1'b0;
            contrast    <= OHP_CONTRAST_RST;
            column_addr <= OHP_COL_RST;
            start_line  <= OHP_START_RST;
            arg_for     <= 2'h0;
        end
        else
        begin
            if (cmd_take)
            begin
                if (arg_for == 2'h1)
                    contrast <= in_word[7:0];
                else if (arg_for == 2'h2)
                    start_line <= in_word[6:0];
                arg_for <= (arg_for != 2'h0) ? 2'h0 :
                           (in_word[7:0] == OHP_CMD_CONTRAST) ? 2'h1 :
                           (in_word[7:0] == OHP_CMD_START) ? 2'h2 : 2'h0;
                if (arg_for == 2'h0 && in_word[7:0] == OHP_CMD_DISP_OFF)
                    display_on <= 1'b0;
                if (arg_for == 2'h0 && in_word[7:0] == OHP_CMD_DISP_ON)
                    display_on <= 1'b1;
            end
            if (dat_take)
                column_addr <= (column_addr == OHP_COL_MAX) ? OHP_COL_RST : column_addr + 8'h01;
        end

    // Read data drive: only while a parallel read is open.
    logic       rd_oe;
    logic [7:0] rd_q;
    always_ff @(posedge mclk or posedge sys_rst)
        if (sys_rst)
        begin
            rd_oe <= 1'b0;
            rd_q  <= 8'h00;
        end
        else
        begin
            rd_oe <= rd68 || rd80;
            if ((m68 && e_rise) || (m80 && rd_fall))
                rd_q <= rd_data;
        end
    assign pins.host_bus_d_out = rd_q;
    assign pins.host_bus_d_oe  = rd_oe;

    // Frame status toggles once per refresh period while the panel is on.
    logic [15:0] fcnt;
    logic        fr;
    always_ff @(posedge mclk or posedge sys_rst)
        if (sys_rst)
        begin
            fcnt <= 16'h0000;
            fr   <= 1'b0;
        end
        else if (fcnt == 16'(OHP_FRAME_CYC - 1))
        begin
            fcnt <= 16'h0000;
            fr   <= fr ^ display_on;
        end
        else
            fcnt <= fcnt + 16'h0001;
    assign pins.frame_status_out = fr;
endmodule : ohp_device

// [ohp_host.sv]
// Host controller end: strap drive, byte-wide writes in any of the four protocols, byte-wide reads in the two parallel ones.
`timescale 1ns/100ps
module ohp_host
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // Pins toward the display
    ohp_if.host              pins,
    // Static configuration
    input  wire logic [1:0]  mode_sel,
    input  wire logic        init_req,
    // Byte request
    input  wire logic [7:0]  tx_data,
    input  wire logic        tx_is_data,
    input  wire logic        tx_read,
    input  wire logic        tx_valid,
    output logic             tx_ready,
    // Read answer
    output logic [7:0]       rd_data,
    output logic             rd_valid,
    // Frame status seen from the display
    output logic             frame_seen
);
    import ohp_pkg::*;

    typedef enum logic [3:0] {
        H_IDLE  = 4'h1,
        H_SETUP = 4'h2,
        H_ACT   = 4'h4,
        H_END   = 4'h8
    } ohp_hstate_t;

    ohp_hstate_t state;
    logic [2:0]  div;
    logic [3:0]  phase;
    logic [8:0]  sh;
    logic        rd;
    logic        dc;
    logic        e_rd;
    logic        rw_wr;
    logic        cs_n;
    logic        sclk;
    logic        oe;
    logic        f1;
    logic        f2;
    wire  tick   = div == 3'(OHP_HOST_DIV - 1);
    wire  serial = (mode_sel == 2'h1) || (mode_sel == 2'h2);
    wire  m68    = mode_sel == 2'h3;
    wire [3:0] nbits = (mode_sel == 2'h1) ? 4'h9 : 4'h8;

    assign tx_ready = (state == H_IDLE) && !init_req;
    assign {pins.protocol_select_high, pins.protocol_select_low} = mode_sel;
    assign pins.init_input_n = !init_req;
    assign pins.cs_n    = cs_n;
    assign pins.dc      = dc;
    assign pins.e_rd_n  = serial ? 1'b0 : e_rd;
    assign pins.rw_wr_n = serial ? 1'b0 : rw_wr;
    // Parallel bytes sit in the upper eight bits of the shifter, the same place the serial path starts from.
    assign pins.host_bus_h_out = serial ? {6'h00, sh[8], sclk} : sh[8:1];
    assign pins.host_bus_h_oe  = serial ? 1'b1 : oe;

    always_ff @(posedge mclk or posedge sys_rst)
        if (sys_rst)
        begin
            f1 <= 1'b0;
            f2 <= 1'b0;
            frame_seen <= 1'b0;
        end
        else
        begin
            f1 <= pins.frame_status_out;
            f2 <= f1;
            frame_seen <= f2;
        end

    always_ff @(posedge mclk or posedge sys_rst)
        if (sys_rst)
        begin
            state <= H_IDLE;
            div   <= 3'h0;
            phase <= 4'h0;
            sh    <= 9'h000;
            rd    <= 1'b0;
            dc    <= 1'b0;
            e_rd  <= 1'b0;
            rw_wr <= 1'b1;
            cs_n  <= 1'b1;
            sclk  <= 1'b0;
            oe    <= 1'b0;
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_valid <= 1'b0;
            div <= tick ? 3'h0 : div + 3'h1;
            case (state)
                H_IDLE:
                begin
                    e_rd  <= !m68;
                    rw_wr <= 1'b1;
                    if (tx_valid && !init_req)
                    begin
                        rd    <= tx_read && !serial;
                        dc    <= tx_is_data;
                        // 3-wire leads with the D/C bit; MSB first otherwise.
                        sh    <= (mode_sel == 2'h1) ? {tx_is_data, tx_data} : {tx_data, 1'b0};
                        cs_n  <= 1'b0;
                        rw_wr <= m68 ? tx_read : 1'b1;
                        oe    <= !tx_read && !serial;
                        phase <= 4'h0;
                        div   <= 3'h0;
                        state <= H_SETUP;
                    end
                end
                H_SETUP:
                    if (tick)
                    begin
                        if (serial)
                            sclk <= 1'b1;
                        else if (m68)
                            e_rd <= 1'b1;
                        else if (rd)
                            e_rd <= 1'b0;
                        else
                            rw_wr <= 1'b0;
                        state <= H_ACT;
                    end
                H_ACT:
                    if (tick)
                    begin
                        if (serial)
                        begin
                            sclk  <= 1'b0;
                            sh    <= {sh[7:0], 1'b0};
                            phase <= phase + 4'h1;
                            state <= (phase == nbits - 4'h1) ? H_END : H_SETUP;
                        end
                        else
                        begin
                            if (rd)
                            begin
                                rd_data  <= pins.host_bus;
                                rd_valid <= 1'b1;
                            end
                            e_rd  <= !m68;
                            // In 68 mode the direction must outlast the falling enable that latches the byte.
                            rw_wr <= m68 ? rw_wr : 1'b1;
                            state <= H_END;
                        end
                    end
                H_END:
                    if (tick)
                    begin
                        cs_n  <= 1'b1;
                        oe    <= 1'b0;
                        state <= H_IDLE;
                    end
                default:
                    state <= H_IDLE;
            endcase
        end
endmodule : ohp_host

// [ohp_chk.sv]
// Pin-level assertions between the host controller and the display port.
`timescale 1ns/100ps
module ohp_chk
(
    // Clock and reset
    input wire logic       mclk,
    input wire logic       sys_rst,
    // Straps and control pins
    input wire logic       protocol_select_low,
    input wire logic       protocol_select_high,
    input wire logic       init_input_n,
    input wire logic       cs_n,
    input wire logic       dc,
    input wire logic       e_rd_n,
    input wire logic       rw_wr_n,
    // Data bus drivers and frame status
    input wire logic [7:0] host_bus_h_out,
    input wire logic       host_bus_h_oe,
    input wire logic [7:0] host_bus_d_out,
    input wire logic       host_bus_d_oe,
    input wire logic [7:0] host_bus,
    input wire logic       frame_status_out
);
    import ohp_pkg::*;
    wire logic [1:0] mode   = {protocol_select_high, protocol_select_low};
    wire logic       serial = (mode == OHP_SPI3) || (mode == OHP_SPI4);
    wire logic       is68   = (mode == OHP_P68);
    wire logic       is80   = (mode == OHP_P80);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    serial_gnd_a:
        assert property (serial |-> !e_rd_n && !rw_wr_n) else $error("strobe pins not grounded in serial mode");
    unused_low_a:
        assert property (serial |-> host_bus[7:2] == 6'h00) else $error("unused bus lines not low in serial mode");
    sclk_still_a:
        assert property (serial && cs_n && $past(cs_n) |-> $stable(host_bus[0])) else $error("serial clock moved");
    dev_select_a:
        assert property (host_bus_d_oe |-> !cs_n) else $error("display drives bus while deselected");
    no_fight_a:
        assert property (!(host_bus_h_oe && host_bus_d_oe)) else $error("both ends drive the bus");
    read68_a:
        assert property (is68 && host_bus_d_oe |-> $past(e_rd_n, 3) && $past(rw_wr_n, 3))
            else $error("68 read drive without strobe");
    read80_a:
        assert property (is80 && host_bus_d_oe |-> !$past(e_rd_n, 3) && $past(rw_wr_n, 3))
            else $error("80 read drive without strobe");
    serial_quiet_a:
        assert property (serial |-> !host_bus_d_oe) else $error("display drives bus in serial mode");
    wr80_pulse_a:
        assert property (is80 && $fell(rw_wr_n) |-> (!rw_wr_n && !cs_n) [*3]) else $error("short 80 write strobe");
    e68_select_a:
        assert property (is68 && $rose(e_rd_n) |-> !cs_n ##1 (e_rd_n && !cs_n) [*2]) else $error("bad 68 enable");
    init_idle_a:
        assert property (!init_input_n |-> cs_n) else $error("access during initialisation");
    rd80_answer_a:
        assert property (is80 && $fell(e_rd_n) && !cs_n |-> ##[1:4] host_bus_d_oe) else $error("no read answer");
endmodule : ohp_chk

// [oled_host_interface_port_test.sv]
// Self-checking bench: host controller and display port joined across the pin interface.
`timescale 1ns/100ps
module oled_host_interface_port_test;
    import ohp_pkg::*;
    logic       mclk;
    logic       sys_rst;
    logic [1:0] mode_sel;
    logic       init_req;
    logic [7:0] tx_data;
    logic       tx_is_data;
    logic       tx_read;
    logic       tx_valid;
    logic       tx_ready;
    logic [7:0] rd_data;
    logic       rd_valid;
    logic       frame_seen;
    logic [7:0] rx_data;
    logic       rx_is_data;
    logic       rx_valid;
    logic       rx_ready;
    logic [7:0] mem_byte;
    logic       display_on;
    logic [7:0] contrast;
    logic [7:0] column_addr;
    logic [6:0] start_line;
    int         err_total;
    int         n_checks;
    int         cyc;

    ohp_if pins ();
    ohp_device i_ohp_device (.mclk(mclk), .sys_rst(sys_rst), .pins(pins), .rx_data(rx_data),
        .rx_is_data(rx_is_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .rd_data(mem_byte),
        .display_on(display_on), .contrast(contrast), .column_addr(column_addr), .start_line(start_line));
    ohp_host i_ohp_host (.mclk(mclk), .sys_rst(sys_rst), .pins(pins), .mode_sel(mode_sel), .init_req(init_req),
        .tx_data(tx_data), .tx_is_data(tx_is_data), .tx_read(tx_read), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rd_data(rd_data), .rd_valid(rd_valid), .frame_seen(frame_seen));
    ohp_chk i_ohp_chk (.mclk(mclk), .sys_rst(sys_rst), .protocol_select_low(pins.protocol_select_low),
        .protocol_select_high(pins.protocol_select_high), .init_input_n(pins.init_input_n), .cs_n(pins.cs_n),
        .dc(pins.dc), .e_rd_n(pins.e_rd_n), .rw_wr_n(pins.rw_wr_n), .host_bus_h_out(pins.host_bus_h_out),
        .host_bus_h_oe(pins.host_bus_h_oe), .host_bus_d_out(pins.host_bus_d_out),
        .host_bus_d_oe(pins.host_bus_d_oe), .host_bus(pins.host_bus), .frame_status_out(pins.frame_status_out));

    initial mclk = 1'b0;
    always #50 mclk = ~mclk;

    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    // A hung handshake must still reach the closing report.
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            err_total++;
            end_of_test();
        end
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Inputs always move 1 ns after the rising edge, clear of the sampling instant.
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    task automatic wait_high(ref logic sig, input string what);
        int k;
        k = 0;
        while (sig !== 1'b1 && k < 800)
        begin
            tick(1);
            k++;
        end
        check(what, {7'h00, sig}, 8'h01);
    endtask : wait_high

    // The request is held up to the edge at which tx_ready is sampled high.
    task automatic send(input logic [7:0] d, input logic is_d, input logic rd);
        wait_high(tx_ready, "tx_ready");
        tx_data = d;
        tx_is_data = is_d;
        tx_read = rd;
        tx_valid = 1'b1;
        tick(1);
        tx_valid = 1'b0;
        tx_read = 1'b0;
        if (rd)
            wait_high(rd_valid, "rd_valid");
        else
            wait_high(tx_ready, "tx_ready");
    endtask : send

    task automatic pop(input string what, input logic [7:0] d, input logic is_d);
        wait_high(rx_valid, "rx_valid");
        check(what, rx_data, d);
        check("rx_is_data", {7'h00, rx_is_data}, {7'h00, is_d});
        rx_ready = 1'b1;
        tick(1);
        rx_ready = 1'b0;
        // An edge passes so that a following pop never lowers and raises rx_ready in one step.
        tick(1);
    endtask : pop

    task automatic xfer(input string what, input logic [7:0] d, input logic is_d);
        send(d, is_d, 1'b0);
        pop(what, d, is_d);
    endtask : xfer

    // Straps are static, so a mode change is made only under reset.
    task automatic set_mode(input logic [1:0] m);
        sys_rst = 1'b1;
        mode_sel = m;
        tick(3);
        sys_rst = 1'b0;
        tick(4);
    endtask : set_mode

    task automatic check_defaults;
        check("display_on", {7'h00, display_on}, 8'h00);
        check("contrast", contrast, OHP_CONTRAST_RST);
        check("column_addr", column_addr, OHP_COL_RST);
        check("start_line", {1'b0, start_line}, {1'b0, OHP_START_RST});
        check("rx_valid", {7'h00, rx_valid}, 8'h00);
    endtask : check_defaults

    task automatic t_modes;
        logic [1:0] m;
        for (int i = 0; i < 4; i++)
        begin
            m = 2'(i);
            set_mode(m);
            xfer("disp_on", OHP_CMD_DISP_ON, 1'b0);
            check("display_on", {7'h00, display_on}, 8'h01);
            send(OHP_CMD_CONTRAST, 1'b0, 1'b0);
            send({6'h24, m}, 1'b0, 1'b0);
            pop("contrast_cmd", OHP_CMD_CONTRAST, 1'b0);
            pop("contrast_arg", {6'h24, m}, 1'b0);
            check("contrast", contrast, {6'h24, m});
            xfer("start_cmd", OHP_CMD_START, 1'b0);
            xfer("start_arg", {6'h08, m}, 1'b0);
            check("start_line", {1'b0, start_line}, {6'h08, m});
            xfer("data", {m, 6'h1a}, 1'b1);
            check("column_addr", column_addr, 8'h01);
        end
    endtask : t_modes

    task automatic t_read;
        set_mode(OHP_P68);
        mem_byte = 8'hc5;
        send(8'h00, 1'b1, 1'b1);
        check("rd68", rd_data, 8'hc5);
        set_mode(OHP_P80);
        mem_byte = 8'h3a;
        send(8'h00, 1'b1, 1'b1);
        check("rd80", rd_data, 8'h3a);
        mem_byte = 8'h96;
        send(8'h00, 1'b1, 1'b1);
        check("rd80_again", rd_data, 8'h96);
    endtask : t_read

    // With the receiver stalled, the third byte finds the two-entry buffer full and is dropped.
    task automatic t_buffer;
        send(8'h11, 1'b1, 1'b0);
        send(8'h22, 1'b1, 1'b0);
        send(8'h33, 1'b1, 1'b0);
        tick(10);
        pop("buf_first", 8'h11, 1'b1);
        pop("buf_second", 8'h22, 1'b1);
        tick(2);
        check("buf_empty", {7'h00, rx_valid}, 8'h00);
    endtask : t_buffer

    task automatic t_init;
        xfer("disp_on", OHP_CMD_DISP_ON, 1'b0);
        xfer("contrast_cmd", OHP_CMD_CONTRAST, 1'b0);
        xfer("contrast_arg", 8'h05, 1'b0);
        send(8'h44, 1'b1, 1'b0);
        init_req = 1'b1;
        tick(8);
        check("init_pin", {7'h00, pins.init_input_n}, 8'h00);
        init_req = 1'b0;
        tick(6);
        check_defaults();
    endtask : t_init

    task automatic t_frame(input logic on, input int exp_min, input int exp_max);
        int n;
        logic prev;
        xfer("disp_cmd", on ? OHP_CMD_DISP_ON : OHP_CMD_DISP_OFF, 1'b0);
        tick(4);
        n = 0;
        prev = pins.frame_status_out;
        repeat (2 * OHP_FRAME_CYC + 100)
        begin
            tick(1);
            if (pins.frame_status_out !== prev)
                n++;
            prev = pins.frame_status_out;
        end
        check("frame_toggles", {7'h00, n >= exp_min && n <= exp_max}, 8'h01);
        if (!on)
            check("frame_seen", {7'h00, frame_seen}, {7'h00, pins.frame_status_out});
    endtask : t_frame

    initial
    begin
        err_total = 0;
        n_checks = 0;
        cyc = 0;
        sys_rst = 1'b1;
        mode_sel = OHP_P80;
        init_req = 1'b0;
        tx_data = 8'h00;
        tx_is_data = 1'b0;
        tx_read = 1'b0;
        tx_valid = 1'b0;
        rx_ready = 1'b0;
        mem_byte = 8'h00;
        tick(3);
        sys_rst = 1'b0;
        tick(4);
        check_defaults();
        t_modes();
        t_read();
        t_buffer();
        t_init();
        t_frame(1'b1, 2, 3);
        t_frame(1'b0, 0, 0);
        end_of_test();
    end
endmodule : oled_host_interface_port_test
